// ===== design/gio_pkg.sv
/*
 * Constants, register offsets and carrier types for the general I/O port.
 * Assumes a single 200 MHz clock and a plain strobe register port.
 */
package gio_pkg;
   localparam int unsigned OUT_W = 16;
   localparam int unsigned AXES = 8;
   localparam int unsigned PIN_W = OUT_W + 2 * AXES;
   // register offsets
   localparam logic [3:0] OFF_SET = 4'h0;
   localparam logic [3:0] OFF_CLR = 4'h1;
   localparam logic [3:0] OFF_COND = 4'h2;
   localparam logic [3:0] OFF_PORT = 4'h3;
   localparam logic [3:0] OFF_SEL = 4'h4;
   localparam logic [3:0] OFF_LEVEL = 4'h5;
   localparam logic [3:0] OFF_GEN = 4'h6;
   localparam logic [3:0] OFF_AUX = 4'h7;
   localparam logic [3:0] OFF_WAIT = 4'h8;
   localparam logic [3:0] OFF_RANGE = 4'h9;
   localparam logic [3:0] OFF_MASK = 4'ha;
   localparam logic [3:0] OFF_RET = 4'hb;
   localparam logic [3:0] OFF_STAT = 4'hc;
   localparam logic [3:0] OFF_STEP = 4'hd;
   // field positions
   localparam int unsigned IDX_LSB = 0;
   localparam int unsigned IDX_W = 8;
   localparam int unsigned OPND_LSB = 8;
   localparam int unsigned END_LSB = 8;
   // index ranges
   localparam logic [7:0] GEN_FIRST = 8'h01;
   localparam logic [7:0] GEN_LAST = 8'h10;
   localparam logic [7:0] AUX_FIRST = 8'h51;
   localparam logic [7:0] AUX_LAST = 8'h60;
   // values after reset
   localparam logic [15:0] OUT_RST = 16'h0000;
   localparam logic [15:0] ARM_RST = 16'h0000;
   localparam logic [7:0] STEP_RST = 8'h00;
   localparam logic [15:0] RD_IDLE = 16'h0000;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } gio_req_t;

   typedef struct packed {
      logic [AXES-1:0] chan_b;
      logic [AXES-1:0] chan_a;
      logic [OUT_W-1:0] gen;
   } gio_pins_t;

   typedef enum logic {IRQ_IDLE, IRQ_HANDLER} gio_irq_st_t;
endpackage

// ===== design/gio_port.sv
/*
 * General I/O port: output latch with bit, conditional and word writes,
 * synchronised input reads, wait-on-level and input interrupt dispatch.
 * Assumes pins are asynchronous and the command interpreter uses the
 * strobe register port and honours o_stall and o_irq_take.
 */
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module gio_port (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire gio_pkg::gio_req_t i_req,
   input wire gio_pkg::gio_pins_t i_pins,
   output logic [15:0] o_rdata,
   output logic [15:0] o_out,
   output logic o_stall,
   output logic o_irq_take,
   output logic o_handler_active,
   output logic o_resume
);
   import gio_pkg::*;

   function automatic logic in_level(input logic [7:0] idx, input logic [31:0] lv);
      logic r;
      r = 1'b0;
      if (idx >= GEN_FIRST && idx <= GEN_LAST)
         r = lv[5'(idx - GEN_FIRST)];
      else if (idx >= AUX_FIRST && idx <= AUX_LAST)
         r = lv[5'(idx - AUX_FIRST) + 5'(OUT_W)];
      return r;
   endfunction

   logic [PIN_W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
   logic [PIN_W-1:0] nxt_lvl;
   logic [PIN_W-1:0] pin_vec;
   logic [PIN_W-1:0] view;
   logic [2*AXES-1:0] aux_pair;
   logic [OUT_W-1:0] out_ff, nxt_out;
   logic [OUT_W-1:0] arm_ff, nxt_arm;
   logic [AXES-1:0] step_ff, nxt_step;
   logic [7:0] sel_ff, nxt_sel;
   logic [7:0] wait_idx_ff, nxt_wait_idx;
   logic wait_ff, nxt_wait;
   logic wait_low_ff, nxt_wait_low;
   logic [15:0] rdata_ff, nxt_rdata;
   gio_irq_st_t irq_st_ff, nxt_irq_st;
   logic take_ff, nxt_take;
   logic resume_ff, nxt_resume;
   logic active_ff, nxt_active;
   logic wr_set, wr_clr, wr_cond, wr_port, wr_ret;
   logic [3:0] bit_sel;
   logic bit_ok;
   logic [7:0] wsel;
   logic [7:0] rng_lo, rng_hi;

   assign pin_vec = i_pins;

   // aux A of axis k at 81+2k, B at 82+2k; stepper axes read as zero
   generate
      for (genvar k = 0; k < AXES; k++) begin : g_aux
         assign aux_pair[2*k] = lvl_ff[OUT_W + k] & ~step_ff[k];
         assign aux_pair[2*k+1] = lvl_ff[OUT_W + AXES + k] & ~step_ff[k];
      end
   endgenerate
   assign view = {aux_pair, lvl_ff[OUT_W-1:0]};

   // a level counts once the second and third stage agree
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         lvl_ff <= '0;
      end else begin
         s1_ff <= pin_vec;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   assign wr_set = i_req.wr && i_req.addr == OFF_SET;
   assign wr_clr = i_req.wr && i_req.addr == OFF_CLR;
   assign wr_cond = i_req.wr && i_req.addr == OFF_COND;
   assign wr_port = i_req.wr && i_req.addr == OFF_PORT;
   assign wr_ret = i_req.wr && i_req.addr == OFF_RET;
   assign wsel = i_req.wdata[IDX_LSB +: IDX_W];
   assign bit_ok = wsel >= GEN_FIRST && wsel <= GEN_LAST;
   assign bit_sel = 4'(wsel - GEN_FIRST);
   assign rng_lo = i_req.wdata[IDX_LSB +: IDX_W];
   assign rng_hi = i_req.wdata[END_LSB +: IDX_W];

   // output latch; indices outside 1..16 are ignored
   always_comb begin
      nxt_out = out_ff;
      if (wr_port)
         nxt_out = i_req.wdata[OUT_W-1:0];
      else if (bit_ok && wr_set)
         nxt_out[bit_sel] = 1'b1;
      else if (bit_ok && wr_clr)
         nxt_out[bit_sel] = 1'b0;
      else if (bit_ok && wr_cond)
         nxt_out[bit_sel] = |i_req.wdata[15:OPND_LSB];
   end

   // configuration: arm mask, stepper axes, input select
   always_comb begin
      nxt_arm = arm_ff;
      nxt_step = step_ff;
      nxt_sel = sel_ff;
      if (i_req.wr && i_req.addr == OFF_RANGE) begin
         for (int i = 0; i < OUT_W; i++) begin
            nxt_arm[i] = (8'(i + 1) >= rng_lo) && (8'(i + 1) <= rng_hi);
         end
      end
      if (i_req.wr && i_req.addr == OFF_MASK)
         nxt_arm = i_req.wdata[OUT_W-1:0];
      if (i_req.wr && i_req.addr == OFF_STEP)
         nxt_step = i_req.wdata[AXES-1:0];
      if (i_req.wr && i_req.addr == OFF_SEL)
         nxt_sel = wsel;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_ff <= OUT_RST;
         arm_ff <= ARM_RST;
         step_ff <= STEP_RST;
         sel_ff <= '0;
      end else begin
         out_ff <= nxt_out;
         arm_ff <= nxt_arm;
         step_ff <= nxt_step;
         sel_ff <= nxt_sel;
      end
   end

   // wait on level: negative index (two's complement) waits for low
   always_comb begin
      nxt_wait = wait_ff;
      nxt_wait_idx = wait_idx_ff;
      nxt_wait_low = wait_low_ff;
      if (wait_ff && in_level(wait_idx_ff, view) != wait_low_ff)
         nxt_wait = 1'b0;
      if (i_req.wr && i_req.addr == OFF_WAIT) begin
         nxt_wait = 1'b1;
         nxt_wait_low = wsel[IDX_W-1];
         nxt_wait_idx = wsel[IDX_W-1] ? 8'(-wsel) : wsel;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_ff <= 1'b0;
         wait_idx_ff <= '0;
         wait_low_ff <= 1'b0;
      end else begin
         wait_ff <= nxt_wait;
         wait_idx_ff <= nxt_wait_idx;
         wait_low_ff <= nxt_wait_low;
      end
   end

   // interrupt stays armed; a held low re-fires right after the return
   always_comb begin
      nxt_irq_st = irq_st_ff;
      nxt_take = 1'b0;
      nxt_resume = 1'b0;
      unique case (irq_st_ff)
         IRQ_IDLE: begin
            if (|(arm_ff & ~lvl_ff[OUT_W-1:0])) begin
               nxt_irq_st = IRQ_HANDLER;
               nxt_take = 1'b1;
            end
         end
         IRQ_HANDLER: begin
            if (wr_ret) begin
               nxt_irq_st = IRQ_IDLE;
               nxt_resume = 1'b1;
            end
         end
      endcase
      nxt_active = nxt_irq_st == IRQ_HANDLER;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_st_ff <= IRQ_IDLE;
         take_ff <= 1'b0;
         resume_ff <= 1'b0;
         active_ff <= 1'b0;
      end else begin
         irq_st_ff <= nxt_irq_st;
         take_ff <= nxt_take;
         resume_ff <= nxt_resume;
         active_ff <= nxt_active;
      end
   end

   // read data stands for one cycle only, zero otherwise
   always_comb begin
      nxt_rdata = RD_IDLE;
      if (i_req.rd) begin
         unique case (i_req.addr)
            OFF_PORT: nxt_rdata = out_ff;
            OFF_SEL: nxt_rdata = {8'h00, sel_ff};
            OFF_LEVEL: nxt_rdata = {15'h0000, in_level(sel_ff, view)};
            OFF_GEN: nxt_rdata = view[OUT_W-1:0];
            OFF_AUX: nxt_rdata = view[PIN_W-1:OUT_W];
            OFF_WAIT: nxt_rdata = {8'h00, wait_low_ff ? 8'(-wait_idx_ff) : wait_idx_ff};
            OFF_MASK: nxt_rdata = arm_ff;
            OFF_STAT: nxt_rdata = {14'h0000, wait_ff, irq_st_ff == IRQ_HANDLER};
            OFF_STEP: nxt_rdata = {8'h00, step_ff};
            default: nxt_rdata = RD_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         rdata_ff <= RD_IDLE;
      else
         rdata_ff <= nxt_rdata;
   end

   assign o_rdata = rdata_ff;
   assign o_out = out_ff;
   assign o_stall = wait_ff;
   assign o_irq_take = take_ff;
   // own copy of the state, so the port comes straight off a flop
   assign o_handler_active = active_ff;
   assign o_resume = resume_ff;

   a_set_bit_three: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_SET && i_req.wdata[7:0] == 8'h03)
      |=> o_out[2] && o_out[1:0] == $past(o_out[1:0]))
      else $error("set of bit 3 failed");
   a_clr_bit_one: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_CLR && i_req.wdata[7:0] == 8'h01)
      |=> !o_out[0] && o_out[15:1] == $past(o_out[15:1]))
      else $error("clear of bit 1 failed");
   a_cond_zero_clr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_COND && i_req.wdata == 16'h0001) |=> !o_out[0])
      else $error("zero operand did not clear");
   a_port_word_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_PORT) |=> o_out == $past(i_req.wdata))
      else $error("word write not loaded");
   a_mask_arm_five: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_MASK && i_req.wdata == 16'h0005)
      |=> arm_ff == 16'h0005)
      else $error("mask arm wrong");
   a_range_arm_span: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_RANGE && i_req.wdata == 16'h0402)
      |=> arm_ff == 16'h000e)
      else $error("range arm wrong");
   a_irq_take_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!o_handler_active && |(arm_ff & ~lvl_ff[OUT_W-1:0]))
      |=> o_irq_take && o_handler_active)
      else $error("armed low not taken");
   a_no_retake_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_handler_active && !wr_ret) |=> !o_irq_take && o_handler_active)
      else $error("interrupt retaken in handler");
   a_return_resume: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_handler_active && wr_ret) |=> o_resume && !o_handler_active ##1 !o_resume)
      else $error("return did not resume");
   a_wait_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_stall && !(i_req.wr && i_req.addr == OFF_WAIT)
      && in_level(wait_idx_ff, view) != wait_low_ff) |=> !o_stall)
      else $error("wait not released");
   a_wait_stall_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.wr && i_req.addr == OFF_WAIT) |=> o_stall)
      else $error("wait did not stall");
   a_take_one_cycle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_irq_take |=> !o_irq_take)
      else $error("take pulse too long");
   a_read_idle_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !i_req.rd |=> o_rdata == RD_IDLE)
      else $error("read data outside its cycle");
   a_out_hold_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !i_req.wr |=> o_out == $past(o_out))
      else $error("outputs changed without a write");
   a_step_aux_hidden: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_req.rd && i_req.addr == OFF_AUX && step_ff[1])
      |=> o_rdata[3:2] == 2'b00)
      else $error("stepper aux input visible");
endmodule

// ===== testbench/gio_pin_model.sv
/*
 * Pin-side model: switches on the general inputs and the aux encoder
 * line receivers. Assumes the bench sets the levels it wants.
 */
`timescale 1ns/1ps
module gio_pin_model (
   input wire logic i_clk,
   input wire logic [15:0] i_gen,
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_b,
   input wire logic [7:0] i_step,
   output gio_pkg::gio_pins_t o_pins
);
   import gio_pkg::*;
   // stepper axes leave their receivers unused: let them wander so a
   // stale level can never pass for a real one
   always @(posedge i_clk) begin
      o_pins.gen <= i_gen;
      o_pins.chan_a <= (i_a & ~i_step) | (~o_pins.chan_a & i_step);
      o_pins.chan_b <= (i_b & ~i_step) | (~o_pins.chan_b & i_step);
   end
endmodule

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for the general I/O port.
 * Assumes the pin model file and the design package are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
   import gio_pkg::*;
   logic i_clk, i_reset_n, stall, take, active, resume;
   gio_req_t req;
   gio_pins_t pins;
   logic [15:0] rdata, out, gen_lv, exp_out, d;
   logic [7:0] a_lv, b_lv, step, opnd;
   logic [31:0] seed = 32'hdc4d, r, lv;
   logic [4:0] idx;
   int err_count = 0, n_checks = 0, seen;

   gio_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_pins(pins),
      .o_rdata(rdata), .o_out(out), .o_stall(stall), .o_irq_take(take),
      .o_handler_active(active), .o_resume(resume));
   gio_pin_model pm (.i_clk(i_clk), .i_gen(gen_lv), .i_a(a_lv), .i_b(b_lv),
      .i_step(step), .o_pins(pins));

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] aux_exp(input logic [7:0] a, b, s);
      logic [15:0] w;
      for (int k = 0; k < 8; k++) begin
         w[2*k] = a[k] & ~s[k];
         w[2*k+1] = b[k] & ~s[k];
      end
      return w;
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   // one strobe cycle; read data is picked up in the cycle after it
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v);
      @(posedge i_clk);
      req <= '{addr: a, wdata: v, wr: w, rd: ~w};
      @(posedge i_clk);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic watch(input int n);
      seen = 0;
      repeat (n) begin
         @(posedge i_clk);
         #1 seen += int'(take === 1'b1);
      end
   endtask

   task automatic settle();
      repeat (6) @(posedge i_clk);
   endtask

   // reset is already low on entry; released by the bench on an edge
   task automatic reset_check();
      settle();
      chk("outputs in reset", OUT_RST, out);
      i_reset_n <= 1'b1;
      bus(1'b0, OFF_MASK, 16'h0);
      chk("arm mask", ARM_RST, d);
   endtask

   task automatic print_verdict();
      $display("checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      print_verdict();
   end

   initial begin
      i_reset_n = 1'b0;
      req = '0;
      {gen_lv, a_lv, b_lv, step, exp_out} = {16'hffff, 40'h0};
      reset_check();
      bus(1'b1, OFF_SET, 16'h0003);
      bus(1'b1, OFF_COND, 16'h0101);
      chk("outputs", 16'h0005, out);
      bus(1'b1, OFF_COND, 16'h0001);
      chk("outputs", 16'h0004, out);
      bus(1'b1, OFF_COND, 16'h0101);
      bus(1'b1, OFF_CLR, 16'h0001);
      chk("outputs", 16'h0004, out);
      exp_out = 16'h0004;
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         idx = (r[12:9] == 4'h0) ? 5'd17 : 5'(r[3:0]) + 5'd1;
         opnd = r[23:16] & {8{r[6]}};
         case (r[5:4])
            2'd0: bus(1'b1, OFF_SET, {11'h0, idx});
            2'd1: bus(1'b1, OFF_CLR, {11'h0, idx});
            2'd2: bus(1'b1, OFF_COND, {opnd, 3'h0, idx});
            default: bus(1'b1, OFF_PORT, r[31:16]);
         endcase
         if (r[5:4] == 2'd3)
            exp_out = r[31:16];
         else if (idx != 5'd17)
            exp_out[idx-1] = (r[5:4] == 2'd0) || (r[5:4] == 2'd2 && opnd != 8'h0);
         chk("outputs", exp_out, out);
      end
      bus(1'b1, OFF_PORT, 16'h8001);
      bus(1'b0, OFF_PORT, 16'h0);
      chk("port word", 16'h8001, d);
      bus(1'b1, OFF_MASK, 16'h0005);
      i_reset_n <= 1'b0;
      reset_check();
      r = rnd();
      {gen_lv, a_lv, b_lv} = r;
      step = (8'(rnd()) & 8'hfe) | 8'h02;
      bus(1'b1, OFF_STEP, {8'h0, step});
      settle();
      bus(1'b0, OFF_STEP, 16'h0);
      chk("stepper axes", {8'h0, step}, d);
      lv = {aux_exp(a_lv, b_lv, step), gen_lv};
      bus(1'b0, OFF_GEN, 16'h0);
      chk("general inputs", gen_lv, d);
      bus(1'b0, OFF_AUX, 16'h0);
      chk("aux inputs", lv[31:16], d);
      for (int i = 0; i < 32; i++) begin
         bus(1'b1, OFF_SEL, 16'((i < 16) ? i + 1 : i + 65));
         bus(1'b0, OFF_LEVEL, 16'h0);
         chk("selected level", {15'h0, lv[i]}, d);
      end
      bus(1'b0, OFF_SEL, 16'h0);
      chk("input select", 16'h0060, d);
      bus(1'b0, 4'hf, 16'h0);
      chk("unmapped read", RD_IDLE, d);
      for (int j = 0; j < 2; j++) begin
         gen_lv[5] = j[0];
         settle();
         bus(1'b1, OFF_WAIT, j ? 16'h00fa : 16'h0006);
         settle();
         chk("stall waiting", 16'h1, {15'h0, stall});
         bus(1'b0, OFF_STAT, 16'h0);
         chk("status waiting", 16'h2, d);
         gen_lv[5] <= ~j[0];
         for (int i = 0; i < 12 && stall !== 1'b0; i++) @(posedge i_clk);
         #1 chk("stall released", 16'h0, {15'h0, stall});
         bus(1'b0, OFF_WAIT, 16'h0);
         chk("wait index", j ? 16'h00fa : 16'h0006, d);
      end
      // random lows still in the synchroniser would fire once armed
      gen_lv = 16'hffff;
      settle();
      bus(1'b1, OFF_RANGE, 16'h0402);
      bus(1'b0, OFF_MASK, 16'h0);
      chk("range mask", 16'h000e, d);
      bus(1'b1, OFF_MASK, 16'h0005);
      gen_lv[1] = 1'b0;
      watch(10);
      chk("unarmed input", 16'h0, 16'(seen));
      gen_lv[2] = 1'b0;
      watch(10);
      chk("handler entry", 16'h1, 16'(seen));
      gen_lv[0] = 1'b0;
      watch(10);
      chk("no retake", 16'h0, 16'(seen));
      bus(1'b0, OFF_STAT, 16'h0);
      chk("status active", 16'h1, d);
      bus(1'b1, OFF_RET, 16'h0);
      chk("resume", 16'h1, {15'h0, resume});
      chk("handler left", 16'h0, {15'h0, active});
      watch(3);
      chk("retake after return", 16'h1, 16'(seen));
      gen_lv = 16'hffff;
      settle();
      bus(1'b1, OFF_RET, 16'h0);
      watch(8);
      chk("quiet after return", 16'h0, 16'(seen));
      print_verdict();
   end
endmodule
